// ===== rtl/safety_field_select_io.sv
// Field pair selection, safety outputs and restart handling
`timescale 1ns/10ps
`default_nettype none
module safety_field_select_io #(
	parameter int unsigned RESTART_MIN_CYCLES =
		safety_io_pkg::RESTART_MIN_CYCLES,
	parameter int unsigned RESTART_MAX_CYCLES =
		safety_io_pkg::RESTART_MAX_CYCLES,
	parameter int unsigned DEBOUNCE_CYCLES = safety_io_pkg::DEBOUNCE_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Field pair select and restart pins
	input wire logic field_pair_select_1,
	input wire logic field_pair_select_2,
	input wire logic field_pair_select_3,
	input wire logic field_pair_select_4,
	input wire logic restartButton,
	// Detection engine status
	input wire logic nearObject,
	input wire logic farObject,
	input wire logic deviceWarning,
	input wire logic deviceError,
	input wire logic deviceReady,
	// Safety outputs
	output logic near_field_ok_ch1,
	output logic near_field_ok_ch2,
	output logic far_field_alarm,
	output logic fault_alarm,
	// Field pair and indicators
	output logic [3:0] activePairs,
	output logic restartLedRed,
	output logic selectFaultLed,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	// Interrupt
	output logic irq
);
	localparam int CW = safety_io_pkg::PRESS_CNT_W;
	localparam int NE = safety_io_pkg::NUM_EVENTS;
	localparam logic [CW-1:0] MIN_CNT = CW'(RESTART_MIN_CYCLES);
	localparam logic [CW-1:0] MAX_CNT = CW'(RESTART_MAX_CYCLES);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		safety_io_pkg::lock_state_e state;
		logic [3:0] active;
		logic [CW-1:0] pressCnt;
		logic pressOn;
		logic pressIgnored;
		logic prevRestart;
		logic [2:0] farMode;
		logic startLockEn;
		logic restartLockEn;
		logic [NE-1:0] status;
		logic [NE-1:0] mask;
		logic [31:0] rdData;
		logic nearOk1;
		logic nearOk2;
		logic farAlarm;
		logic faultAlarm;
		logic ledRed;
		logic selLed;
		logic irq;
	} top_s;

	localparam top_s RESET_S = '{
		state: safety_io_pkg::ST_START_LOCK,
		active: safety_io_pkg::DEFAULT_PAIR,
		farMode: safety_io_pkg::FAR_MODE_RESET,
		startLockEn: 1'b1,
		restartLockEn: 1'b1,
		mask: safety_io_pkg::MASK_RESET,
		default: '0
	};

	top_s s;
	top_s next_s;

	// Selects high, shared by the default and fault tests
	function automatic logic [2:0] countHigh(input logic [3:0] v);
		countHigh = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
	endfunction : countHigh

	// ------------------------------------------------------------
	// Input filtering
	// ------------------------------------------------------------
	// Restart rides with the selects so all share one delay
	input_filter_if filt ();

	assign filt.raw = {restartButton, field_pair_select_4,
		field_pair_select_3, field_pair_select_2, field_pair_select_1};

	input_filter #(
		.FILTER_CYCLES(DEBOUNCE_CYCLES)
	) u_filter (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.port(filt.filter)
	);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		logic [3:0] sel;
		logic restart;
		logic [2:0] nHigh;
		logic selFault;
		logic opReady;
		logic pulseEnd;
		logic pulseGood;
		logic nearClear;
		logic farCond;
		logic [NE-1:0] events;
		sel = filt.clean[3:0];
		restart = filt.clean[safety_io_pkg::RESTART_BIT];
		nHigh = countHigh(sel);
		selFault = nHigh > safety_io_pkg::MAX_OVERLAP;
		opReady = deviceReady && !deviceError;
		pulseEnd = 1'b0;
		pulseGood = 1'b0;
		farCond = 1'b0;
		nearClear = 1'b0;
		events = '0;
		next_s = s;

		// Selection is applied as soon as filtered, well inside any
		// configured response time
		if (nHigh == 3'h0) begin
			next_s.active = safety_io_pkg::DEFAULT_PAIR;
		end else if (!selFault) begin
			next_s.active = sel;
		end

		// Restart pulse measurement; nothing is released until the
		// pin falls, so a button held forever never frees a lock
		next_s.prevRestart = restart;
		if (restart && !s.prevRestart) begin
			next_s.pressOn = 1'b1;
			next_s.pressCnt = CW'(1);
			next_s.pressIgnored = !opReady;
		end else if (restart && s.pressOn) begin
			// Saturate just past the maximum so an overlong press stays bad
			if (s.pressCnt <= MAX_CNT) begin
				next_s.pressCnt = s.pressCnt + CW'(1);
			end
			if (!opReady) begin
				next_s.pressIgnored = 1'b1;
			end
		end
		if (!restart && s.prevRestart && s.pressOn) begin
			next_s.pressOn = 1'b0;
			pulseEnd = !s.pressIgnored;
			pulseGood = !s.pressIgnored && s.pressCnt >= MIN_CNT
				&& s.pressCnt <= MAX_CNT;
		end

		// Lock state machine
		// Only a measured, completed pulse, or a disabled start lock, leaves a lock
		case (s.state)
			safety_io_pkg::ST_START_LOCK: begin
				if (!s.startLockEn || pulseGood) begin
					next_s.state = safety_io_pkg::ST_RUN;
				end
			end
			safety_io_pkg::ST_RESTART_LOCK: begin
				if (pulseGood) begin
					next_s.state = safety_io_pkg::ST_RUN;
				end
			end
			safety_io_pkg::ST_RUN: begin
				if (nearObject && s.restartLockEn) begin
					next_s.state = safety_io_pkg::ST_RESTART_LOCK;
				end
			end
			default: begin
				next_s.state = safety_io_pkg::ST_START_LOCK;
			end
		endcase
		// A device error drops back to the start lock for recovery
		if (deviceError) begin
			next_s.state = safety_io_pkg::ST_START_LOCK;
		end

		// Safety outputs
		// Both channels share one term so they never disagree
		nearClear = s.state == safety_io_pkg::ST_RUN && !nearObject
			&& !restart
			&& !selFault
			&& opReady;
		next_s.nearOk1 = nearClear;
		next_s.nearOk2 = nearClear;

		// Role set by software; unused codes report nothing
		case (s.farMode)
			safety_io_pkg::FAR_MODE_FIELD: farCond = farObject;
			safety_io_pkg::FAR_MODE_WARNING: farCond = deviceWarning;
			safety_io_pkg::FAR_MODE_EITHER: farCond = farObject || deviceWarning;
			safety_io_pkg::FAR_MODE_NONE: farCond = 1'b0;
			safety_io_pkg::FAR_MODE_ERROR: farCond = deviceError;
			default: farCond = 1'b0;
		endcase
		next_s.farAlarm = opReady && !farCond
			&& !selFault;
		next_s.faultAlarm = opReady && !deviceWarning
			&& !selFault;
		next_s.ledRed = restart;
		next_s.selLed = selFault;

		// Event capture
		events[safety_io_pkg::EV_SEL_FAULT] = selFault;
		events[safety_io_pkg::EV_NEAR_OBJECT] = nearObject;
		events[safety_io_pkg::EV_RESTART_OK] = pulseGood;
		events[safety_io_pkg::EV_RESTART_BAD] = pulseEnd && !pulseGood;
		events[safety_io_pkg::EV_DEV_ERROR] = deviceError;
		events[safety_io_pkg::EV_DEV_WARNING] = deviceWarning;

		// Register writes
		// Status bits clear only where a one is written
		if (regWr) begin
			case (regAddr)
				safety_io_pkg::REG_CONFIG: begin
					next_s.farMode =
						regWrData[safety_io_pkg::CFG_FAR_MODE_LSB +: 3];
					next_s.startLockEn =
						regWrData[safety_io_pkg::CFG_START_LOCK_BIT];
					next_s.restartLockEn =
						regWrData[safety_io_pkg::CFG_RESTART_LOCK_BIT];
				end
				safety_io_pkg::REG_STATUS: begin
					next_s.status = s.status & ~regWrData[NE-1:0];
				end
				safety_io_pkg::REG_MASK: begin
					next_s.mask = regWrData[NE-1:0];
				end
				default: begin
				end
			endcase
		end
		// Set after clear so a same-cycle event is never lost
		next_s.status = next_s.status | events;
		next_s.irq = |(next_s.status & next_s.mask);

		// Register reads, data valid only in the following cycle
		// Unmapped addresses and reserved bits read as zero
		next_s.rdData = '0;
		if (regRd) begin
			case (regAddr)
				safety_io_pkg::REG_CONFIG: begin
					next_s.rdData[safety_io_pkg::CFG_FAR_MODE_LSB +: 3] =
						s.farMode;
					next_s.rdData[safety_io_pkg::CFG_START_LOCK_BIT] =
						s.startLockEn;
					next_s.rdData[safety_io_pkg::CFG_RESTART_LOCK_BIT] =
						s.restartLockEn;
				end
				safety_io_pkg::REG_STATUS: next_s.rdData[NE-1:0] = s.status;
				safety_io_pkg::REG_MASK: next_s.rdData[NE-1:0] = s.mask;
				safety_io_pkg::REG_STATE: begin
					next_s.rdData[1:0] = s.state;
					next_s.rdData[7:4] = s.active;
					next_s.rdData[8] = s.nearOk1;
					next_s.rdData[9] = s.farAlarm;
					next_s.rdData[10] = s.faultAlarm;
					next_s.rdData[11] = s.pressOn;
				end
				default: next_s.rdData = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s <= RESET_S;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Straight from the state register: no glitch reaches a relay
	assign near_field_ok_ch1 = s.nearOk1;
	assign near_field_ok_ch2 = s.nearOk2;
	assign far_field_alarm = s.farAlarm;
	assign fault_alarm = s.faultAlarm;
	assign activePairs = s.active;
	assign restartLedRed = s.ledRed;
	assign selectFaultLed = s.selLed;
	assign regRdData = s.rdData;
	assign irq = s.irq;

endmodule : safety_field_select_io
`default_nettype wire

// ===== rtl/safety_io_pkg.sv
// Constants, types and reset values shared by the safety field select logic
// How it works
// - Each high select input activates its field pair, up to two high
// - No select input high selects pair one
// - All four high: warning, near outputs off
// - Two high during changeover: both pairs active
// - Over two pairs selected: far alarm fault
// - Switchover completes within the response time
// - Near outputs high only while near field clear
// - Far alarm high when ready, low per mode
// - Device error forces every safety output low
// - Fault alarm low on any warning or error
// - Valid restart pulse releases start and restart lock
// - While restart held: near off, red indicator
// - Restart acted on only when operationally ready
package safety_io_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned CLK_KHZ = CLK_HZ / 1000;
	localparam int unsigned RESTART_MIN_MS = 120;
	localparam int unsigned RESTART_MAX_MS = 3000;
	localparam int unsigned DEBOUNCE_US = 1000;
	// Whole milliseconds times whole kHz: exact, no rounding needed
	localparam int unsigned RESTART_MIN_CYCLES = RESTART_MIN_MS * CLK_KHZ;
	localparam int unsigned RESTART_MAX_CYCLES = RESTART_MAX_MS * CLK_KHZ;
	localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_KHZ / 1000;
	localparam int PRESS_CNT_W = 27;
	localparam int FILTER_CNT_W = 15;

	// ------------------------------------------------------------
	// Inputs and field pairs
	// ------------------------------------------------------------
	localparam int NUM_SELECT = 4;
	localparam int NUM_FILTERED = 5;
	localparam int RESTART_BIT = 4;
	localparam logic [3:0] DEFAULT_PAIR = 4'h1;
	localparam logic [2:0] MAX_OVERLAP = 3'h2;

	// ------------------------------------------------------------
	// Register map (byte offsets)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CONFIG = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MASK = 8'h08;
	localparam logic [7:0] REG_STATE = 8'h0C;

	// Config fields
	localparam int CFG_FAR_MODE_LSB = 0;
	localparam int CFG_START_LOCK_BIT = 4;
	localparam int CFG_RESTART_LOCK_BIT = 5;
	localparam logic [2:0] FAR_MODE_RESET = 3'h0;

	// Far alarm signalling choices
	localparam logic [2:0] FAR_MODE_FIELD = 3'h0;
	localparam logic [2:0] FAR_MODE_WARNING = 3'h1;
	localparam logic [2:0] FAR_MODE_EITHER = 3'h2;
	localparam logic [2:0] FAR_MODE_NONE = 3'h3;
	localparam logic [2:0] FAR_MODE_ERROR = 3'h4;

	// Status / mask bits
	localparam int EV_SEL_FAULT = 0;
	localparam int EV_NEAR_OBJECT = 1;
	localparam int EV_RESTART_OK = 2;
	localparam int EV_RESTART_BAD = 3;
	localparam int EV_DEV_ERROR = 4;
	localparam int EV_DEV_WARNING = 5;
	localparam int NUM_EVENTS = 6;
	localparam logic [5:0] MASK_RESET = 6'h00;

	typedef enum logic [1:0] {
		ST_START_LOCK,
		ST_RESTART_LOCK,
		ST_RUN
	} lock_state_e;

endpackage : safety_io_pkg

// ===== rtl/input_filter_if.sv
// Carrier between the safety logic and its input filter
`timescale 1ns/10ps
`default_nettype none
interface input_filter_if;
	logic [safety_io_pkg::NUM_FILTERED-1:0] raw;
	logic [safety_io_pkg::NUM_FILTERED-1:0] clean;
	modport owner (output raw, input clean);
	modport filter (input raw, output clean);
endinterface : input_filter_if
`default_nettype wire

// ===== rtl/input_filter.sv
// Two-stage synchroniser and stability filter for the discrete inputs
`timescale 1ns/10ps
`default_nettype none
module input_filter #(
	parameter int unsigned FILTER_CYCLES = safety_io_pkg::DEBOUNCE_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Raw in, filtered out
	input_filter_if.filter port
);
	localparam int N = safety_io_pkg::NUM_FILTERED;
	localparam int W = safety_io_pkg::FILTER_CNT_W;

	typedef struct packed {
		logic [N-1:0] meta;
		logic [N-1:0] sync;
		logic [N-1:0] clean;
		logic [N-1:0][W-1:0] cnt;
	} filter_s;

	filter_s s;
	filter_s next_s;

	always_comb begin
		next_s = s;
		next_s.meta = port.raw;
		next_s.sync = s.meta;
		for (int i = 0; i < N; i++) begin
			// A level must hold for the full window before it is believed
			if (s.sync[i] == s.clean[i]) begin
				next_s.cnt[i] = '0;
			end else if (s.cnt[i] >= W'(FILTER_CYCLES - 1)) begin
				next_s.clean[i] = s.sync[i];
				next_s.cnt[i] = '0;
			end else begin
				next_s.cnt[i] = s.cnt[i] + W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign port.clean = s.clean;

endmodule : input_filter
`default_nettype wire

// ===== verification/safety_field_select_io_chk.sv
// Concurrent checks on the safety outputs of the field select block
`timescale 1ns/10ps
`default_nettype none
module safety_field_select_io_chk #(
	parameter int unsigned RESTART_MIN_CYCLES = 20,
	parameter int unsigned RESTART_MAX_CYCLES = 60,
	parameter int unsigned DEBOUNCE_CYCLES = 4
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Pins and engine status
	input wire logic field_pair_select_1,
	input wire logic field_pair_select_2,
	input wire logic field_pair_select_3,
	input wire logic field_pair_select_4,
	input wire logic nearObject,
	input wire logic deviceError,
	input wire logic deviceReady,
	// Outputs
	input wire logic near_field_ok_ch1,
	input wire logic near_field_ok_ch2,
	input wire logic far_field_alarm,
	input wire logic fault_alarm,
	input wire logic [3:0] activePairs,
	input wire logic restartLedRed,
	input wire logic selectFaultLed
);
	// Filter plus sync plus output stage, with three cycles of margin
	localparam int unsigned SETTLE = DEBOUNCE_CYCLES + 6;
	logic [3:0] sel;
	logic [3:0] lastSel;
	logic [7:0] stableCnt;
	assign sel = {field_pair_select_4, field_pair_select_3,
		field_pair_select_2, field_pair_select_1};
	always_ff @(posedge clk_sys) begin
		lastSel <= sel;
		if (!resetn || sel != lastSel)
			stableCnt <= 8'h00;
		else if (stableCnt != 8'hFF)
			stableCnt <= stableCnt + 8'h01;
	end
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sel_track_a: assert property (
		stableCnt == SETTLE && $countones(sel) < 3 |->
		activePairs == ((sel == 4'h0) ? 4'h1 : sel) && !selectFaultLed)
		else $error("active pairs do not follow the pins");
	sel_fault_a: assert property (
		stableCnt == SETTLE && $countones(sel) > 2 |-> selectFaultLed)
		else $error("select fault not flagged");
	fault_outs_a: assert property (
		selectFaultLed |-> !near_field_ok_ch1 && !near_field_ok_ch2 &&
		!fault_alarm && !far_field_alarm)
		else $error("outputs on during select fault");
	pair_count_a: assert property (
		$countones(activePairs) inside {[1:2]})
		else $error("active pair count out of range");
	filter_hold_a: assert property (
		$changed(activePairs) |-> stableCnt >= DEBOUNCE_CYCLES)
		else $error("pairs moved before pins were stable");
	err_low_a: assert property (
		deviceError |=> !near_field_ok_ch1 && !near_field_ok_ch2 &&
		!far_field_alarm && !fault_alarm)
		else $error("output high during device error");
	not_ready_a: assert property (
		!deviceReady |=> !far_field_alarm && !fault_alarm)
		else $error("alarm high while not ready");
	near_obj_a: assert property (
		nearObject |=> !near_field_ok_ch1 && !near_field_ok_ch2)
		else $error("near output high with object");
	near_twin_a: assert property (
		near_field_ok_ch1 == near_field_ok_ch2)
		else $error("near channels disagree");
	restart_led_a: assert property (
		restartLedRed |-> !near_field_ok_ch1 && !near_field_ok_ch2)
		else $error("near output high during restart");
endmodule : safety_field_select_io_chk
bind safety_field_select_io safety_field_select_io_chk #(
	.RESTART_MIN_CYCLES(RESTART_MIN_CYCLES),
	.RESTART_MAX_CYCLES(RESTART_MAX_CYCLES),
	.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) chk (.*);
`default_nettype wire

// ===== verification/safety_io_partner.sv
// Model of the controller and restart button on the pin side
`timescale 1ns/10ps
`default_nettype none
module safety_io_partner (
	// Clock
	input wire logic clk_sys,
	// Select and restart pins
	output logic [3:0] selPins,
	output logic restartPin
);
	initial begin
		selPins = 4'h0;
		restartPin = 1'b0;
	end
	// New pair first, old one later: empty only when the target is empty
	task automatic move_to(input logic [3:0] target, input int hold);
		@(posedge clk_sys);
		selPins <= selPins | target;
		repeat (hold) @(posedge clk_sys);
		selPins <= target;
	endtask : move_to
	// Length in cycles; only the bench asks for illegal ones
	task automatic press(input int unsigned len);
		@(posedge clk_sys);
		restartPin <= 1'b1;
		repeat (len) @(posedge clk_sys);
		restartPin <= 1'b0;
	endtask : press
endmodule : safety_io_partner
`default_nettype wire

// ===== verification/safety_field_select_io_tb.sv
// Self-checking bench for the field select and safety outputs
`timescale 1ns/10ps
`default_nettype none
module safety_field_select_io_tb;
	localparam int unsigned MIN_C = 20;
	localparam int unsigned MAX_C = 60;
	localparam int SETTLE = 16;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic nearObject = 1'b0;
	logic farObject = 1'b0;
	logic deviceWarning = 1'b0;
	logic deviceError = 1'b0;
	logic deviceReady = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0000_0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic outCheck = 1'b0;
	logic rdSeen = 1'b0;
	logic [31:0] rng = 32'h0000_A22B;
	logic [3:0] pairs = 4'h1;
	logic [3:0] v;
	logic ok;
	logic [3:0] selPins;
	logic restartPin;
	logic nearOk1, nearOk2, farAlarm, faultAlarm, irq;
	logic [3:0] activePairs;
	logic [31:0] regRdData;
	logic [31:0] expReg[$];
	logic [8:0] expOut[$];
	int num_errors = 0;
	int check_count = 0;

	safety_io_partner partner (.clk_sys(clk_sys), .selPins(selPins),
		.restartPin(restartPin));
	safety_field_select_io #(.RESTART_MIN_CYCLES(MIN_C),
		.RESTART_MAX_CYCLES(MAX_C), .DEBOUNCE_CYCLES(4)) dut (
		.clk_sys(clk_sys), .resetn(resetn),
		.field_pair_select_1(selPins[0]), .field_pair_select_2(selPins[1]),
		.field_pair_select_3(selPins[2]), .field_pair_select_4(selPins[3]),
		.restartButton(restartPin), .nearObject(nearObject),
		.farObject(farObject), .deviceWarning(deviceWarning),
		.deviceError(deviceError), .deviceReady(deviceReady),
		.near_field_ok_ch1(nearOk1), .near_field_ok_ch2(nearOk2),
		.far_field_alarm(farAlarm), .fault_alarm(faultAlarm),
		.activePairs(activePairs), .restartLedRed(), .selectFaultLed(),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .irq(irq));

	initial forever #20 clk_sys = ~clk_sys;

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift

	task automatic end_sim;
		$display("checks %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	task automatic compare(input logic [31:0] got, input logic [31:0] want);
		check_count++;
		if (got !== want) begin
			num_errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got,
				want);
		end
	endtask : compare

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expReg.push_back(e);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
	endtask : rd

	// Flags are irq, near, far, fault
	task automatic chk(input logic [3:0] f, input logic [3:0] p);
		repeat (SETTLE) @(posedge clk_sys);
		expOut.push_back({f[3], f[2], f[2], f[1], f[0], p});
		outCheck <= 1'b1;
		@(posedge clk_sys);
		outCheck <= 1'b0;
	endtask : chk

	// Optional press, then the event, its interrupt and the clear
	task automatic pr(input int unsigned len, input logic [31:0] st,
		input logic n);
		if (len != 0)
			partner.press(len);
		chk({1'b1, n, 2'h3}, 4'h1);
		rd(8'h04, st);
		wr(8'h04, 32'h0000_003F);
		chk({1'b0, n, 2'h3}, 4'h1);
	endtask : pr

	// Read data stand one cycle after the strobe
	initial forever begin
		@(posedge clk_sys);
		if (rdSeen)
			compare(regRdData, expReg.pop_front());
		rdSeen = regRd;
		if (outCheck)
			compare(32'({irq, nearOk1, nearOk2, farAlarm, faultAlarm,
				activePairs}), 32'(expOut.pop_front()));
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		$display("watchdog expired");
		end_sim();
	end

	initial begin
		repeat (6) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(8'h00, 32'h0000_0030);
		rd(8'h10, 32'h0000_0000);
		chk(4'h3, 4'h1);
		$display("test reset done");
		deviceReady <= 1'b0;
		chk(4'h0, 4'h1);
		partner.press(MIN_C * 2);
		deviceReady <= 1'b1;
		chk(4'h3, 4'h1);
		rd(8'h04, 32'h0000_0000);
		$display("test not ready done");
		wr(8'h08, 32'h0000_000C);
		pr(MIN_C - 1, 32'h0000_0008, 1'b0);
		pr(MIN_C * 2, 32'h0000_0004, 1'b1);
		fork
			partner.press(MAX_C + 1);
			chk(4'h3, 4'h1);
		join
		pr(0, 32'h0000_0008, 1'b1);
		$display("test restart done");
		nearObject <= 1'b1;
		chk(4'h3, 4'h1);
		nearObject <= 1'b0;
		chk(4'h3, 4'h1);
		pr(MAX_C, 32'h0000_0006, 1'b1);
		$display("test near object done");
		for (int i = 0; i < 14; i++) begin
			rng = xorshift(rng);
			v = (i < 12) ? rng[3:0] : ((i == 12) ? 4'hF : 4'h0);
			ok = $countones(v) < 3;
			if (ok)
				pairs = (v == 4'h0) ? 4'h1 : v;
			partner.move_to(v, SETTLE);
			chk({1'b0, ok, ok, ok}, pairs);
		end
		$display("test selection done");
		for (int m = 0; m < 5; m++) begin
			wr(8'h00, 32'h0000_0030 | 32'(m));
			farObject <= 1'b1;
			chk({2'h1, !(m == 0 || m == 2), 1'b1}, 4'h1);
			farObject <= 1'b0;
			deviceWarning <= 1'b1;
			chk({2'h1, !(m == 1 || m == 2), 1'b0}, 4'h1);
			deviceWarning <= 1'b0;
		end
		$display("test far modes done");
		wr(8'h00, 32'h0000_0030);
		wr(8'h04, 32'h0000_003F);
		deviceError <= 1'b1;
		chk(4'h0, 4'h1);
		deviceError <= 1'b0;
		chk(4'h3, 4'h1);
		pr(MIN_C, 32'h0000_0014, 1'b1);
		$display("test device error done");
		// Shorter than the filter window: never seen
		partner.press(3);
		chk(4'h7, 4'h1);
		rd(8'h04, 32'h0000_0000);
		rd(8'h08, 32'h0000_000C);
		wr(8'h00, 32'h0000_0000);
		nearObject <= 1'b1;
		chk(4'h3, 4'h1);
		nearObject <= 1'b0;
		chk(4'h7, 4'h1);
		deviceError <= 1'b1;
		chk(4'h0, 4'h1);
		deviceError <= 1'b0;
		chk(4'h7, 4'h1);
		rd(8'h0C, 32'h0000_0712);
		rd(8'h00, 32'h0000_0000);
		$display("test lock options done");
		end_sim();
	end
endmodule : safety_field_select_io_tb
`default_nettype wire
